// ---- remote_node.sv ----
`timescale 1ns/1ps
module remote_node #(
	parameter int BIT = 64
) (
	// Clock and line
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	task automatic hold(input logic v, input int n);
		line_out <= v;
		repeat (n) @(negedge clk);
	endtask
	// low start, LSB first, stop, idle high
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		@(negedge clk);
		hold(1'b0, BIT);
		for (int i = 0; i < n; i++) hold(d[i], BIT);
		// Short bad stop, so no false start follows it
		hold(stop, stop ? BIT : BIT * 3 / 4);
		hold(1'b1, BIT * 2);
	endtask
	task automatic glitch(input int n);
		@(negedge clk);
		hold(1'b0, n);
		hold(1'b1, BIT);
	endtask
	// find start, sample each bit centre
	task automatic recv(input int n, input logic inv,
		output logic [8:0] d, output logic stop);
		int t;
		t = 0;
		d = 9'h000;
		stop = 1'bx;
		while ((line_in ^ inv) !== 1'b0 && t < 5000) begin
			@(negedge clk);
			t++;
		end
		if (t >= 5000) begin
			d = 'x;
		end else begin
			repeat (BIT / 2) @(negedge clk);
			for (int i = 0; i < n; i++) begin
				repeat (BIT) @(negedge clk);
				d[i] = line_in ^ inv;
			end
			repeat (BIT) @(negedge clk);
			stop = line_in ^ inv;
		end
	endtask
endmodule

// ---- rx_char_fifo.sv ----
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module rx_char_fifo (
	// Clock and clear
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// Write side
	input wire logic push,
	input wire serial_port_pkg::rx_char_t wdata,
	// Read side
	input wire logic pop,
	output serial_port_pkg::rx_char_t rdata,
	output logic [1:0] count
);
	import serial_port_pkg::*;
	rx_char_t mem [0:1];
	logic wr_ptr;
	logic rd_ptr;
	wire do_pop = pop && (count != 2'd0);
	wire do_push = push && (count != `FIFO_DEPTH);
	assign rdata = mem[rd_ptr];
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (do_push) begin
				mem[wr_ptr] <= wdata;
				wr_ptr <= ~wr_ptr;
			end
			if (do_pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, do_push} - {1'b0, do_pop};
		end
	end
endmodule

// ---- serial_port_pkg.sv ----
package serial_port_pkg;
	typedef struct packed {
		logic port_enable;
		logic tx_enable;
		logic rx_enable;
		logic tx_invert;
		logic tx_nine_bit_mode;
		logic rx_nine_bit_mode;
	} port_cfg_t;
	typedef struct packed {
		logic frame_err;
		logic [8:0] data;
	} rx_char_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// ---- serial_port_regs.svh ----
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
// Oversample ticks per bit and half bit
`define OVERSAMPLE 5'd16
`define HALF_BIT 4'd7
`define LAST_TICK 4'hF
// Majority sample points within a bit
`define VOTE_A 4'd7
`define VOTE_B 4'd8
`define VOTE_C 4'd9
// Character lengths in data bits, and receive FIFO depth
`define BITS_EIGHT 4'd8
`define BITS_NINE 4'd9
`define FIFO_DEPTH 2'd2
`endif

// ---- serial_tx_rx.sv ----
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_tx_rx (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration and baud tick
	input wire serial_port_pkg::port_cfg_t cfg,
	input wire logic baud_tick,
	// Transmit side
	input wire logic tx_write,
	input wire logic [7:0] tx_data,
	input wire logic tx_ninth_bit,
	output logic tx_space_flag,
	output logic tx_shift_empty,
	output logic tx_pin,
	// Receive side
	input wire logic rx_pin,
	input wire logic rx_read,
	output logic [8:0] rx_data,
	output logic rx_frame_err_flag,
	output logic rx_overrun_flag,
	output logic rx_avail_flag,
	// Interrupt enables and request
	input wire logic rx_irq_en,
	input wire logic periph_irq_en,
	input wire logic global_irq_en,
	output logic rx_irq
);
	import serial_port_pkg::*;

	// Transmitter
	tx_state_t tx_state;
	logic [8:0] tx_holding_reg;
	logic hold_full;
	logic [8:0] tx_shift_reg;
	logic [3:0] tx_tick;
	logic [3:0] tx_bit;
	logic tx_line;
	wire tx_on = cfg.port_enable && cfg.tx_enable;
	wire [3:0] tx_len = cfg.tx_nine_bit_mode ? `BITS_NINE : `BITS_EIGHT;
	wire tx_bit_end = baud_tick && (tx_tick == `LAST_TICK);
	wire tx_idle = (tx_state == TX_IDLE);
	wire [8:0] tx_word = {cfg.tx_nine_bit_mode & tx_ninth_bit, tx_data};
	wire load_direct = tx_write && tx_idle && !hold_full;
	wire load_queued = hold_full && tx_idle;
	wire tx_load = tx_on && (load_direct || load_queued);

	always_ff @(posedge clk) begin
		if (!rst_n || !tx_on) begin
			hold_full <= 1'b0;
			tx_holding_reg <= 9'h000;
		end else if (tx_write && !load_direct) begin
			hold_full <= 1'b1;
			tx_holding_reg <= tx_word;
		end else if (load_queued) begin
			hold_full <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !tx_on) begin
			tx_state <= TX_IDLE;
			tx_shift_reg <= 9'h000;
			tx_tick <= 4'h0;
			tx_bit <= 4'h0;
			tx_line <= 1'b1;
		end else begin
			if (baud_tick)
				tx_tick <= tx_tick + 4'h1;
			unique case (tx_state)
				TX_IDLE: begin
					tx_line <= 1'b1;
					if (tx_load) begin
						tx_shift_reg <= load_direct ? tx_word : tx_holding_reg;
						tx_state <= TX_START;
						tx_tick <= 4'h0;
						tx_line <= 1'b0;
					end
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_state <= TX_DATA;
						tx_bit <= 4'h0;
						tx_line <= tx_shift_reg[0];
					end
				end
				TX_DATA: begin
					if (tx_bit_end) begin
						tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == tx_len - 4'h1) begin
							tx_state <= TX_STOP;
							tx_line <= 1'b1;
						end else begin
							tx_line <= tx_shift_reg[1];
						end
					end
				end
				TX_STOP: begin
					if (tx_bit_end)
						tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			tx_pin <= 1'b1;
		else
			tx_pin <= tx_line ^ cfg.tx_invert;
	end

	// no software path to the flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_space_flag <= 1'b0;
			tx_shift_empty <= 1'b1;
		end else begin
			tx_space_flag <= tx_on && !hold_full;
			tx_shift_empty <= tx_idle && !tx_load;
		end
	end

	// Receiver input synchroniser
	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= rx_pin;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	rx_state_t rx_state;
	logic [3:0] rx_tick;
	logic [3:0] rx_bit;
	logic [8:0] rx_shift_reg;
	logic [1:0] vote;
	logic overrun;
	rx_char_t fifo_out;
	logic [1:0] fifo_count;
	logic push;
	rx_char_t push_char;
	wire rx_on = cfg.port_enable && cfg.rx_enable;
	wire [3:0] rx_len = cfg.rx_nine_bit_mode ? `BITS_NINE : `BITS_EIGHT;
	wire falling = rx_prev && !rx_sync;
	wire at_vote = (rx_tick == `VOTE_A) || (rx_tick == `VOTE_B)
		|| (rx_tick == `VOTE_C);
	wire bit_val = (vote + {1'b0, rx_sync}) >= 2'd2;
	wire [8:0] rx_aligned = cfg.rx_nine_bit_mode ? rx_shift_reg
		: {1'b0, rx_shift_reg[8:1]};
	wire fifo_full = (fifo_count == `FIFO_DEPTH);

	always_ff @(posedge clk) begin
		if (!rst_n || !rx_on) begin
			rx_state <= RX_IDLE;
			rx_tick <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift_reg <= 9'h000;
			vote <= 2'd0;
			push <= 1'b0;
			push_char <= '0;
		end else begin
			push <= 1'b0;
			unique case (rx_state)
				RX_IDLE: begin
					rx_tick <= 4'h0;
					if (falling && !overrun)
						rx_state <= RX_START;
				end
				RX_START: begin
					if (baud_tick) begin
						rx_tick <= rx_tick + 4'h1;
						if (rx_tick == `HALF_BIT && rx_sync)
							rx_state <= RX_IDLE;
						// Run out the start bit so votes land mid-bit
						if (rx_tick == `LAST_TICK) begin
							rx_state <= RX_DATA;
							rx_bit <= 4'h0;
							vote <= 2'd0;
						end
					end
				end
				RX_DATA: begin
					if (baud_tick) begin
						rx_tick <= rx_tick + 4'h1;
						if (at_vote && rx_tick != `VOTE_C)
							vote <= vote + {1'b0, rx_sync};
						if (rx_tick == `VOTE_C) begin
							vote <= 2'd0;
							rx_shift_reg <= {bit_val, rx_shift_reg[8:1]};
						end
						if (rx_tick == `LAST_TICK) begin
							rx_bit <= rx_bit + 4'h1;
							if (rx_bit == rx_len - 4'h1)
								rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (baud_tick) begin
						rx_tick <= rx_tick + 4'h1;
						if (rx_tick == `VOTE_B) begin
							push <= 1'b1;
							push_char.data <= rx_aligned;
							push_char.frame_err <= !rx_sync;
							rx_state <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !rx_on)
			overrun <= 1'b0;
		else if (push && fifo_full)
			overrun <= 1'b1;
	end

	rx_char_fifo fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(!cfg.port_enable),
		.push(push && !overrun),
		.wdata(push_char),
		.pop(rx_read),
		.rdata(fifo_out),
		.count(fifo_count)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_data <= 9'h000;
			rx_frame_err_flag <= 1'b0;
			rx_overrun_flag <= 1'b0;
			rx_avail_flag <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			rx_data <= fifo_out.data;
			rx_frame_err_flag <= (fifo_count != 2'd0) && fifo_out.frame_err;
			rx_overrun_flag <= overrun || (push && fifo_full && rx_on);
			rx_avail_flag <= rx_on && (fifo_count != 2'd0);
			rx_irq <= rx_on && (fifo_count != 2'd0) && rx_irq_en
				&& periph_irq_en && global_irq_en;
		end
	end

	// Assertions
	// shift empty clears on load
	shift_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
		tx_load |=> !tx_shift_empty)
		else $error("shift empty not cleared on load");
	start_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		tx_load && !cfg.tx_invert |=> ##1 !tx_pin)
		else $error("start bit missing after load");
	space_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		##1 tx_space_flag == $past(tx_on && !hold_full))
		else $error("space flag wrong");
	space_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
		tx_write && !tx_idle && tx_on |-> ##2 !tx_space_flag)
		else $error("space flag not cleared after queued write");
	avail_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		rx_on && fifo_count != 2'd0 |=> rx_avail_flag)
		else $error("avail flag missing");
	irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		rx_irq |-> $past(rx_irq_en && periph_irq_en && global_irq_en))
		else $error("irq without all enables");
	overrun_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		push && fifo_full && rx_on |=> overrun)
		else $error("overrun not set");
	overrun_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		overrun && !rx_read |=> fifo_count == $past(fifo_count))
		else $error("FIFO grew during overrun");
	start_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
		rx_on && rx_state == RX_START && baud_tick && rx_tick == `HALF_BIT
		&& rx_sync |=> rx_state == RX_IDLE)
		else $error("false start not abandoned");
endmodule

// ---- serial_tx_rx_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("unexpected %0t %h %h", $time, a, b); end end
module serial_tx_rx_tb;
	import serial_port_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic baud_tick = 1'b0;
	logic [1:0] div = 2'h0;
	logic tx_write = 1'b0;
	logic tx_ninth_bit = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic rx_read = 1'b0;
	logic rx_irq_en = 1'b0;
	logic periph_irq_en = 1'b0;
	logic global_irq_en = 1'b0;
	port_cfg_t cfg = '0;
	logic tx_space_flag, tx_shift_empty, tx_pin, rx_pin, rx_irq;
	logic rx_frame_err_flag, rx_overrun_flag, rx_avail_flag;
	logic [8:0] rx_data, got;
	logic stp;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	// Tick every 4 cycles: one bit is 64 cycles
	always @(negedge clk) begin
		div <= div + 2'h1;
		baud_tick <= (div == 2'h3);
	end
	serial_tx_rx uut (.clk(clk), .rst_n(rst_n), .cfg(cfg),
		.baud_tick(baud_tick), .tx_write(tx_write), .tx_data(tx_data),
		.tx_ninth_bit(tx_ninth_bit), .tx_space_flag(tx_space_flag),
		.tx_shift_empty(tx_shift_empty), .tx_pin(tx_pin), .rx_pin(rx_pin),
		.rx_read(rx_read), .rx_data(rx_data),
		.rx_frame_err_flag(rx_frame_err_flag),
		.rx_overrun_flag(rx_overrun_flag), .rx_avail_flag(rx_avail_flag),
		.rx_irq_en(rx_irq_en), .periph_irq_en(periph_irq_en),
		.global_irq_en(global_irq_en), .rx_irq(rx_irq));
	remote_node #(.BIT(64)) partner (.clk(clk), .line_in(tx_pin),
		.line_out(rx_pin));
	task conclude;
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wr(input logic [7:0] d, input logic n9);
		tx_data = d;
		tx_ninth_bit = n9;
		tx_write = 1'b1;
		cyc(1);
		tx_write = 1'b0;
	endtask
	task rd;
		rx_read = 1'b1;
		cyc(1);
		rx_read = 1'b0;
	endtask
	task rx_chk(input logic [8:0] d, input int n, input logic inv);
		partner.recv(n, inv, got, stp);
		`CHK(got, d)
		`CHK(stp, 1'b1)
	endtask
	initial begin
		cyc(12);
		rst_n = 1'b1;
		cyc(1);
		`CHK({tx_pin, tx_shift_empty, tx_space_flag, rx_avail_flag}, 4'hC)
		cfg.port_enable = 1'b1;
		cyc(1);
		cfg.tx_enable = 1'b1;
		cfg.rx_enable = 1'b1;
		cyc(2);
		`CHK(tx_space_flag, 1'b1)
		wr(8'hA5, 1'b0);
		cyc(2);
		`CHK({tx_shift_empty, tx_space_flag}, 2'h1)
		wr(8'h3C, 1'b0);
		cyc(2);
		`CHK(tx_space_flag, 1'b0)
		rx_chk(9'h0A5, 8, 1'b0);
		rx_chk(9'h03C, 8, 1'b0);
		cyc(80);
		`CHK({tx_shift_empty, tx_space_flag}, 2'h3)
		// ninth bit goes with the write
		cfg.tx_nine_bit_mode = 1'b1;
		wr(8'h3C, 1'b1);
		rx_chk(9'h13C, 9, 1'b0);
		cfg.tx_nine_bit_mode = 1'b0;
		cyc(80);
		cfg.tx_invert = 1'b1;
		cyc(2);
		`CHK(tx_pin, 1'b0)
		wr(8'h96, 1'b0); // last character, no irq enable raised
		rx_chk(9'h096, 8, 1'b1);
		cfg.tx_invert = 1'b0;
		cyc(80);
		partner.send(9'h055, 8, 1'b1);
		partner.send(9'h00F, 8, 1'b0);
		partner.send(9'h0F0, 8, 1'b1);
		`CHK({rx_avail_flag, rx_overrun_flag, rx_frame_err_flag}, 3'h6)
		`CHK(rx_data[7:0], 8'h55)
		rd;
		cyc(1);
		`CHK({rx_data[7:0], rx_frame_err_flag}, 9'h01F)
		rd;
		cyc(1);
		`CHK({rx_avail_flag, rx_overrun_flag}, 2'h1)
		cfg.rx_enable = 1'b0;
		cyc(2);
		`CHK(rx_overrun_flag, 1'b0)
		cfg.rx_enable = 1'b1;
		partner.glitch(8);
		cyc(200);
		`CHK(rx_avail_flag, 1'b0)
		cfg.rx_nine_bit_mode = 1'b1;
		partner.send(9'h1A5, 9, 1'b1);
		`CHK(rx_data, 9'h1A5)
		cfg.rx_enable = 1'b0;
		cyc(2);
		`CHK(rx_avail_flag, 1'b0)
		cfg.rx_enable = 1'b1;
		cyc(2);
		`CHK(rx_avail_flag, 1'b1)
		for (int i = 0; i < 8; i++) begin
			{rx_irq_en, periph_irq_en, global_irq_en} = i[2:0];
			cyc(2);
			`CHK(rx_irq, (i == 7))
		end
		rd;
		cyc(2);
		`CHK({rx_avail_flag, rx_irq}, 2'h0)
		conclude();
	end
endmodule
